/* File: inc/asf_pkg.sv */
// Package of constants and types for the acceleration sample buffer.
package asf_pkg;
  localparam int unsigned DEPTH       = 32;
  localparam int unsigned PTR_W       = 5;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned SAMPLE_W    = 16;
  localparam int unsigned NUM_AXES    = 3;
  localparam int unsigned ADDR_W      = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WTM      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_OUT_X    = 8'h14;
  localparam logic [7:0] OFS_OUT_Y    = 8'h18;
  localparam logic [7:0] OFS_OUT_Z    = 8'h1C;
  localparam logic [7:0] OFS_POP      = 8'h20;

  // Control fields.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ENA_LSB  = 4;
  localparam int unsigned CTRL_AINC_BIT = 8;

  // Event bit positions, shared by status, enable and mask.
  localparam int unsigned EV_WTM   = 0;
  localparam int unsigned EV_EMPTY = 1;
  localparam int unsigned EV_FULL  = 2;

  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [2:0]  ENA_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST = 3'h0;
  localparam logic [5:0]  WTM_RST  = 6'h10;
  localparam logic [31:0] DEC_ERR  = 32'hDEAD_0BAD;

  typedef enum logic [1:0] {
    ASF_BYPASS      = 2'b00,
    ASF_FILL_STOP   = 2'b01,
    ASF_STREAM      = 2'b10,
    ASF_STREAM_FILL = 2'b11
  } asf_mode_t;

  typedef logic [SAMPLE_W-1:0] asf_sample_t;
endpackage

/* File: inc/asf_store_if.sv */
// Interface carrying sample writes and pops between the controller and the storage.
`timescale 1ns/1ps
interface asf_store_if;
  logic                  wr_en;
  logic [4:0]            wr_ptr;
  logic [47:0]           wr_data;
  logic [4:0]            rd_ptr;
  logic [47:0]           rd_data;
  modport ctrl (output wr_en, output wr_ptr, output wr_data, output rd_ptr, input rd_data);
  modport mem  (input wr_en, input wr_ptr, input wr_data, input rd_ptr, output rd_data);
endinterface

/* File: core/asf_axis_mem.sv */
// Per-axis sample storage, one array per axis written in step.
`timescale 1ns/1ps
module asf_axis_mem (
  // Clock
  input wire logic aclk,
  // Storage port
  asf_store_if.mem st
);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_axis
      asf_pkg::asf_sample_t mem [asf_pkg::DEPTH];
      always_ff @(posedge aclk) begin
        if (st.wr_en) begin
          mem[st.wr_ptr] <= st.wr_data[g*16 +: 16];
        end
      end
      assign st.rd_data[g*16 +: 16] = mem[st.rd_ptr];
    end
  endgenerate
endmodule

/* File: core/asf_sync.sv */
// Two-stage synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module asf_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

/* File: core/asf_top.sv */
// Acceleration sample buffer with AXI4-Lite registers and event interrupts.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module asf_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Measurement chain
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_x,
  input  wire logic [15:0] sample_y,
  input  wire logic [15:0] sample_z,
  input  wire logic        trigger,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Events
  output logic [1:0]       event_output_lines,
  output logic             irq,
  output logic             data_ready
);
  // Response codes of the register bus.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  asf_store_if st ();

  asf_axis_mem u_mem (
    .aclk (aclk),
    .st   (st)
  );

  // The trigger comes from event logic that may sit on another clock.
  logic trig_s;
  logic trig_d_r;
  asf_sync u_trig (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (trigger),
    .dout    (trig_s)
  );
  // Only the rising edge counts, so a trigger held high fires once.
  wire trig_pulse = trig_s & ~trig_d_r;

  asf_pkg::asf_mode_t mode_r;
  logic [2:0]         ena_r;
  logic               ainc_r;
  logic [5:0]         wtm_r;
  logic [2:0]         mask_r;
  logic [2:0]         ev_stat_r;
  logic [4:0]         wr_ptr_r;
  logic [4:0]         rd_ptr_r;
  logic [5:0]         cnt_r;
  logic               triggered_r;
  logic [15:0]        out_x_r;
  logic [15:0]        out_y_r;
  logic [15:0]        out_z_r;
  logic [1:0]         burst_idx_r;

  // Write channel. Address and data may arrive in either order; each is parked until both are in
  // and the response slot is free, so a slow bready stalls the next write rather than losing it.
  logic [7:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  wire         wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire         mode_wr = wr_go && aw_addr_r == asf_pkg::OFS_CTRL && w_strb_r[0];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= asf_pkg::OFS_POP);
  endfunction

  // The first output register starts each set, both for pops and for the burst walk.
  function automatic logic starts_set(input logic [7:0] a);
    starts_set = a == asf_pkg::OFS_OUT_X;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_have_r & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers.
  // A byte-0 control write is a mode write even when the mode does not change, and restarts the buffer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= asf_pkg::ASF_BYPASS;
      ena_r  <= asf_pkg::ENA_RST;
      ainc_r <= 1'b0;
      wtm_r  <= asf_pkg::WTM_RST;
      mask_r <= asf_pkg::MASK_RST;
    end else if (wr_go) begin
      unique case (aw_addr_r)
        asf_pkg::OFS_CTRL: begin
          if (w_strb_r[0]) begin
            mode_r <= asf_pkg::asf_mode_t'(w_data_r[asf_pkg::CTRL_MODE_LSB +: 2]);
            ena_r  <= w_data_r[asf_pkg::CTRL_ENA_LSB +: 3];
          end
          if (w_strb_r[1]) begin
            ainc_r <= w_data_r[asf_pkg::CTRL_AINC_BIT];
          end
        end
        asf_pkg::OFS_WTM: begin
          if (w_strb_r[0]) begin
            wtm_r <= w_data_r[5:0];
          end
        end
        asf_pkg::OFS_IRQ_MASK: begin
          if (w_strb_r[0]) begin
            mask_r <= w_data_r[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel; the pop happens when a read address is taken.
  logic [7:0] ar_addr_r;
  logic       ar_go_r;
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire        is_buf  = mode_r != asf_pkg::ASF_BYPASS;
  wire        pop_hit = ar_take && is_buf && (s_axi_araddr == asf_pkg::OFS_POP ||
                        (starts_set(s_axi_araddr) && (!ainc_r || burst_idx_r == 2'd0)));
  wire        do_pop  = pop_hit && cnt_r != 6'd0;
  wire        stat_rd = ar_take && s_axi_araddr == asf_pkg::OFS_IRQ_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_addr_r   <= 8'h00;
      ar_go_r     <= 1'b0;
      burst_idx_r <= 2'd0;
    end else begin
      ar_go_r <= ar_take;
      if (ar_take) begin
        ar_addr_r <= s_axi_araddr;
        // Burst reads walk X, Y, Z and pop again only on the next X.
        if (starts_set(s_axi_araddr)) begin
          burst_idx_r <= 2'd1;
        end else if (s_axi_araddr == asf_pkg::OFS_OUT_Z) begin
          burst_idx_r <= 2'd0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      // Ready stays low from the handshake until the answer is taken, so one read at most is in flight.
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~ar_go_r;
      if (ar_go_r) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(ar_addr_r) ? RESP_OKAY : RESP_SLVERR;
        unique case (ar_addr_r)
          asf_pkg::OFS_CTRL:     s_axi_rdata <= {23'h0, ainc_r, 1'b0, ena_r, 2'b00, mode_r};
          asf_pkg::OFS_WTM:      s_axi_rdata <= {26'h0, wtm_r};
          asf_pkg::OFS_STATUS:   s_axi_rdata <= {25'h0, triggered_r, cnt_r};
          asf_pkg::OFS_IRQ_STAT: s_axi_rdata <= {29'h0, ev_stat_r};
          asf_pkg::OFS_IRQ_MASK: s_axi_rdata <= {29'h0, mask_r};
          asf_pkg::OFS_OUT_X:    s_axi_rdata <= {16'h0, out_x_r};
          asf_pkg::OFS_OUT_Y:    s_axi_rdata <= {16'h0, out_y_r};
          asf_pkg::OFS_OUT_Z:    s_axi_rdata <= {16'h0, out_z_r};
          asf_pkg::OFS_POP:      s_axi_rdata <= {26'h0, cnt_r};
          // Unmapped reads return a marker word along with the error response.
          default:               s_axi_rdata <= asf_pkg::DEC_ERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Write acceptance per mode.
  // Fill-stop drops a set that meets a full buffer, unless a pop frees a slot in the same cycle.
  wire full_now  = cnt_r == 6'(asf_pkg::DEPTH);
  wire fill_stop = mode_r == asf_pkg::ASF_FILL_STOP ||
                   (mode_r == asf_pkg::ASF_STREAM_FILL && triggered_r);
  wire do_wr     = sample_valid && is_buf && !(fill_stop && full_now && !do_pop);
  wire overwrite = do_wr && full_now && !do_pop;

  // Bypass keeps writing the first slot of each axis; the pointers are held at zero there.
  wire byp_wr = sample_valid && !is_buf;
  assign st.wr_en   = do_wr | byp_wr;
  assign st.wr_ptr  = wr_ptr_r;
  assign st.wr_data = {sample_z, sample_y, sample_x};
  assign st.rd_ptr  = rd_ptr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r    <= 5'd0;
      rd_ptr_r    <= 5'd0;
      cnt_r       <= 6'd0;
      triggered_r <= 1'b0;
      trig_d_r    <= 1'b0;
    end else begin
      trig_d_r <= trig_s;
      if (mode_wr || !is_buf) begin
        wr_ptr_r    <= 5'd0;
        rd_ptr_r    <= 5'd0;
        cnt_r       <= 6'd0;
        triggered_r <= 1'b0;
      end else begin
        if (trig_pulse && mode_r == asf_pkg::ASF_STREAM_FILL) begin
          triggered_r <= 1'b1;
        end
        // The pointers are exactly as wide as the depth needs, so they wrap at the end of the array.
        if (do_wr) begin
          wr_ptr_r <= wr_ptr_r + 5'd1;
        end
        if (do_pop || overwrite) begin
          rd_ptr_r <= rd_ptr_r + 5'd1;
        end
        // A pop and a write in one cycle leave the count as it is.
        if (do_wr && !do_pop && !overwrite) begin
          cnt_r <= cnt_r + 6'd1;
        end else if (do_pop && !do_wr) begin
          cnt_r <= cnt_r - 6'd1;
        end
      end
    end
  end

  // Output data registers: live sample in bypass, popped set otherwise.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_x_r <= 16'h0000;
      out_y_r <= 16'h0000;
      out_z_r <= 16'h0000;
    end else if (!is_buf) begin
      if (sample_valid) begin
        out_x_r <= sample_x;
        out_y_r <= sample_y;
        out_z_r <= sample_z;
      end
    end else if (do_pop) begin
      // The array is read in the handshake cycle, so the new set is in place before the read data is loaded.
      out_x_r <= st.rd_data[15:0];
      out_y_r <= st.rd_data[31:16];
      out_z_r <= st.rd_data[47:32];
    end
  end

  // Events: level conditions gated by enables set sticky bits.
  logic [2:0] ev_now;
  always_comb begin
    ev_now                    = 3'b000;
    ev_now[asf_pkg::EV_WTM]   = is_buf && cnt_r >= wtm_r && wtm_r != 6'd0;
    ev_now[asf_pkg::EV_EMPTY] = is_buf && cnt_r == 6'd0;
    ev_now[asf_pkg::EV_FULL]  = is_buf && full_now;
    ev_now                    = ev_now & ena_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_stat_r <= 3'b000;
    end else if (mode_wr) begin
      ev_stat_r <= 3'b000;
    end else begin
      // A read clears the bits, but an event in the same cycle is kept.
      ev_stat_r <= (stat_rd ? 3'b000 : ev_stat_r) | ev_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq                <= 1'b0;
      event_output_lines <= 2'b00;
      data_ready         <= 1'b0;
    end else begin
      irq                   <= |(ev_stat_r & mask_r);
      // Line 0 carries the watermark alone; line 1 shares empty and full, told apart in the status.
      event_output_lines[0] <= ev_stat_r[asf_pkg::EV_WTM] & mask_r[asf_pkg::EV_WTM];
      event_output_lines[1] <= |(ev_stat_r[2:1] & mask_r[2:1]);
      // The strobe is echoed one cycle late, in line with the other registered outputs.
      data_ready            <= sample_valid;
    end
  end
endmodule

/* File: bench/asf_top_checker.sv */
// Concurrent checks on the ports of the acceleration sample buffer.
`timescale 1ns/1ps
module asf_top_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Samples and events
  input wire logic        sample_valid,
  input wire logic        data_ready,
  input wire logic        irq,
  input wire logic [1:0]  event_output_lines,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  strobe_echo_a: assert property (sample_valid |=> data_ready)
    else $error("data_ready did not follow the strobe");
  strobe_cause_a: assert property (data_ready |-> $past(sample_valid))
    else $error("data_ready without a strobe");
  irq_lines_a: assert property (irq == |event_output_lines)
    else $error("irq disagrees with the event lines");
  reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  read_busy_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read accepted while busy");
  cover property ($rose(irq));
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind asf_top asf_top_checker asf_top_checker_i (.aclk, .aresetn, .sample_valid, .data_ready, .irq,
  .event_output_lines, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* File: bench/asf_host_model.sv */
// Host model: an AXI4-Lite master that reaches the buffer registers.
`timescale 1ns/1ps
module asf_host_model (
  // Clock and pacing
  input  wire logic        aclk,
  input  wire logic        slow,
  output logic             tmo,
  // Write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    tmo = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  end
  // One transfer; when slow, the answer is taken late to exercise the slave's hold.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w && !slow;
    s_axi_rready <= !w && !slow;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n == 4) s_axi_bready <= w;
      if (n == 4) s_axi_rready <= !w;
      if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) break;
    end
    rd = s_axi_rdata;
    r = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    tmo <= (n == 64);
  endtask
endmodule

/* File: bench/asf_top_bench.sv */
// Self-checking bench for the acceleration sample buffer.
`timescale 1ns/1ps
module asf_top_bench;
  logic aclk, aresetn, sample_valid, trigger, slow, tmo, irq, data_ready;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] sample_x, sample_y, sample_z;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, event_output_lines;
  int n_errors, cmp_count;
  asf_top asf_top_i (.aclk, .aresetn, .sample_valid, .sample_x, .sample_y, .sample_z, .trigger,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_output_lines,
    .irq, .data_ready);
  asf_host_model asf_host_model_i (.aclk, .slow, .tmo, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge tmo) begin
    n_errors++;
    stop_test();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    asf_host_model_i.xfer(1'h0, a, 32'h0000_0000, d, r);
    chk(nm, e, d & m);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic [1:0] r;
    asf_host_model_i.xfer(1'h1, a, wd, d, r);
    chk("write resp", 32'h0000_0000, {30'h0, r});
  endtask
  task automatic mode(input asf_pkg::asf_mode_t m, input logic [31:0] x);
    wr_reg(asf_pkg::OFS_CTRL, {30'h0, m} | 32'h0000_0070 | x);
  endtask
  // A pop read returns the count left after it; c is the count before the first pop.
  task automatic pop_n(input int n, input int c);
    for (int i = 0; i < n; i++) begin
      rc(asf_pkg::OFS_POP, 32'h0000_003F, (c > i) ? 32'(c - 1 - i) : 32'h0000_0000, "pop count");
    end
  endtask
  // Every set carries the same offset per axis, so a swapped axis shows at once.
  task automatic push(input int n, input logic [15:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      sample_valid <= 1'h1;
      sample_x <= b + 16'(i);
      sample_y <= b + 16'(i) + 16'h0100;
      sample_z <= b + 16'(i) + 16'h0200;
      @(posedge aclk);
      sample_valid <= 1'h0;
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc(asf_pkg::OFS_WTM, 32'h0000_003F, {26'h0, asf_pkg::WTM_RST}, "wtm reset");
    rc(asf_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0000, "mode reset");
    asf_host_model_i.xfer(1'h0, 8'h40, 32'h0000_0000, d, r);
    chk("unmapped data", asf_pkg::DEC_ERR, d);
    chk("unmapped resp", 32'h0000_0002, {30'h0, r});
    asf_host_model_i.xfer(1'h1, 8'h40, 32'h0000_0000, d, r);
    chk("unmapped write", 32'h0000_0002, {30'h0, r});
  endtask
  task automatic t_burst();
    slow = 1'h1;
    mode(asf_pkg::ASF_FILL_STOP, 32'h0000_0100);
    push(2, 16'h6000);
    rc(asf_pkg::OFS_OUT_X, 32'h0000_FFFF, 32'h0000_6000, "burst x");
    rc(asf_pkg::OFS_OUT_Y, 32'h0000_FFFF, 32'h0000_6100, "burst y");
    rc(asf_pkg::OFS_OUT_Z, 32'h0000_FFFF, 32'h0000_6200, "burst z");
    rc(asf_pkg::OFS_OUT_X, 32'h0000_FFFF, 32'h0000_6001, "burst next x");
    slow = 1'h0;
  endtask
  task automatic t_bypass();
    mode(asf_pkg::ASF_BYPASS, 32'h0000_0000);
    push(3, 16'h1000);
    rc(asf_pkg::OFS_STATUS, 32'h0000_003F, 32'h0000_0000, "bypass count");
    rc(asf_pkg::OFS_OUT_X, 32'h0000_FFFF, 32'h0000_1002, "bypass live x");
  endtask
  task automatic t_fill();
    mode(asf_pkg::ASF_FILL_STOP, 32'h0000_0000);
    wr_reg(asf_pkg::OFS_IRQ_MASK, 32'h0000_0007);
    push(33, 16'h2000);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    chk("event lines", 32'h0000_0003, {30'h0, event_output_lines});
    rc(asf_pkg::OFS_STATUS, 32'h0000_003F, 32'h0000_0020, "full count");
    rc(asf_pkg::OFS_IRQ_STAT, 32'h0000_0005, 32'h0000_0005, "wtm full");
    rc(asf_pkg::OFS_OUT_X, 32'h0000_FFFF, 32'h0000_2000, "oldest x");
    rc(asf_pkg::OFS_OUT_Z, 32'h0000_FFFF, 32'h0000_2200, "oldest z");
    pop_n(1, 31);
    rc(asf_pkg::OFS_OUT_Y, 32'h0000_FFFF, 32'h0000_2101, "next y");
    rc(asf_pkg::OFS_STATUS, 32'h0000_003F, 32'h0000_001E, "after pops");
    pop_n(31, 30);
    rc(asf_pkg::OFS_STATUS, 32'h0000_003F, 32'h0000_0000, "drained");
    rc(asf_pkg::OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002, "empty");
    rc(asf_pkg::OFS_IRQ_STAT, 32'h0000_0005, 32'h0000_0000, "read clear");
    wr_reg(asf_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk("masked irq", 32'h0000_0000, {31'h0, irq});
  endtask
  task automatic t_stream();
    mode(asf_pkg::ASF_STREAM, 32'h0000_0000);
    push(34, 16'h3000);
    rc(asf_pkg::OFS_STATUS, 32'h0000_003F, 32'h0000_0020, "stream count");
    rc(asf_pkg::OFS_OUT_X, 32'h0000_FFFF, 32'h0000_3002, "overwritten");
  endtask
  task automatic t_trig();
    mode(asf_pkg::ASF_STREAM_FILL, 32'h0000_0000);
    rc(asf_pkg::OFS_STATUS, 32'h0000_007F, 32'h0000_0000, "mode clear");
    push(34, 16'h4000);
    @(posedge aclk);
    trigger <= 1'h1;
    @(posedge aclk);
    trigger <= 1'h0;
    repeat (5) @(posedge aclk);
    rc(asf_pkg::OFS_STATUS, 32'h0000_007F, 32'h0000_0060, "triggered");
    pop_n(1, 32);
    push(2, 16'h5000);
    pop_n(32, 32);
    rc(asf_pkg::OFS_OUT_Y, 32'h0000_FFFF, 32'h0000_5100, "kept first");
  endtask
  initial begin
    n_errors = 0;
    cmp_count = 0;
    {aresetn, sample_valid, trigger, slow} = 4'h0;
    {sample_x, sample_y, sample_z} = 48'h0000_0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_burst();
    t_bypass();
    t_fill();
    t_stream();
    t_trig();
    stop_test();
  end
endmodule
